// ===== logic/bps_pkg.sv
package bps_pkg;
	localparam int BPS_MAX_ENTRIES = 120;
	localparam int BPS_SEQ_AW = 7;
	localparam int BPS_MEM_BLOCK_BITS = 512;
	localparam int BPS_MEM_BLOCKS = 65536;
	localparam int BPS_MEM_AW = 25;
	localparam int BPS_MEM_DW = 32;
	localparam int BPS_WORD_AW = 20;
	localparam int BPS_WORD_SEL_W = 5;
	localparam int BPS_ORD_MIN = 7;
	localparam int BPS_ORD_MAX = 23;
	localparam int BPS_ORD_W = 5;
	localparam int BPS_LFSR_W = 23;
	localparam int BPS_ERR_W = 32;
	localparam int BPS_LEN_W = 32;
	localparam int BPS_SLOTS = 12;
	localparam int BPS_SLOT_W = 4;
	localparam int BPS_SYNC_WIN = 64;
	localparam int BPS_SYNC_WIN_W = 7;
	localparam logic [BPS_SYNC_WIN_W-1:0] BPS_SYNC_MAX_ERR = 7'h01;
	localparam int BPS_FIFO_DEPTH = 4;
	localparam int BPS_CLKDIV_W = 8;
	typedef enum logic [2:0]
	{
		BPS_BLK_PAUSE0 = 3'h0,
		BPS_BLK_PAUSE1 = 3'h1,
		BPS_BLK_CLOCK = 3'h2,
		BPS_BLK_HWPRBS = 3'h3,
		BPS_BLK_MEMORY = 3'h4
	} bps_blk_e;
	typedef enum logic [1:0]
	{
		BPS_ST_IDLE = 2'h0,
		BPS_ST_RUN = 2'h1,
		BPS_ST_REJECT = 2'h2
	} bps_state_e;
	// Feedback taps of a maximal-length LFSR for orders 7, 9, 10, 11, 15, 20 and 23; any other order gets the order-7 taps
	function automatic logic [BPS_LFSR_W-1:0] bps_taps(input logic [BPS_ORD_W-1:0] ord);
		logic [BPS_LFSR_W-1:0] t;
		t = '0;
		unique case (ord)
			5'h07: t = 23'h000060;
			5'h09: t = 23'h000110;
			5'h0A: t = 23'h000240;
			5'h0B: t = 23'h000500;
			5'h0F: t = 23'h006000;
			5'h14: t = 23'h090000;
			5'h17: t = 23'h420000;
			default: t = 23'h000060;
		endcase
		return t;
	endfunction
	// One LFSR step, shifted left, masked to the order's length
	function automatic logic [BPS_LFSR_W-1:0] bps_step(input logic [BPS_LFSR_W-1:0] s,
		input logic [BPS_ORD_W-1:0] ord);
		logic fb;
		logic [BPS_LFSR_W-1:0] m;
		fb = ^(s & bps_taps(ord));
		m = (23'h000001 << ord) - 23'h000001;
		return ({s[BPS_LFSR_W-2:0], fb}) & m;
	endfunction
	function automatic logic bps_msb(input logic [BPS_LFSR_W-1:0] s, input logic [BPS_ORD_W-1:0] ord);
		return s[ord - 5'h01];
	endfunction
endpackage

// ===== logic/bps_fifo.sv
`timescale 1ns/100ps
module bps_fifo
	import bps_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter int DEPTH = BPS_FIFO_DEPTH
)
(
	input wire logic clk_in, // Clock
	input wire logic sys_rst_in, // Sync reset
	input wire logic [WIDTH-1:0] wr_data_in, // Write data
	input wire logic wr_valid_in, // Write valid
	output logic wr_ready_out, // Not full
	output logic [WIDTH-1:0] rd_data_out, // Head data
	output logic rd_valid_out, // Not empty
	input wire logic rd_ready_in // Consumer ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = wr_valid_in && wr_ready_out;
	wire pop = rd_valid_out && rd_ready_in;
	assign wr_ready_out = (count != (AW+1)'(DEPTH));
	assign rd_valid_out = (count != '0);
	assign rd_data_out = mem[rd_ptr];
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wr_ptr] <= wr_data_in;
		if (sys_rst_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ===== logic/bps_sequencer.sv
`timescale 1ns/100ps
module bps_sequencer
	import bps_pkg::*;
(
	input wire logic clk_in, // System clock 20 MHz
	input wire logic sys_rst_in, // Sync reset, active high
	input wire logic clk_sel_aux_in, // Mux clock source: 1 auxiliary
	output logic clk_sel_aux_out, // Registered clock source select
	input wire logic start_in, // Start sequence pulse
	input wire logic stop_in, // Stop pulse
	input wire logic [BPS_SEQ_AW-1:0] num_blocks_in, // Blocks used
	input wire logic [BPS_SEQ_AW-1:0] num_loops_in, // Counted loops used
	input wire logic seq_we_in, // Sequence table write
	input wire logic [BPS_SEQ_AW-1:0] seq_addr_in, // Table entry
	input wire logic [2:0] seq_kind_in, // Block kind
	input wire logic [BPS_LEN_W-1:0] seq_len_in, // Block length in bits
	input wire logic [BPS_ORD_W-1:0] seq_ord_in, // PRBS order or clock half-period
	input wire logic [BPS_MEM_AW-1:0] seq_base_in, // Memory start bit
	input wire logic seq_loop_end_in, // Entry closes a loop
	input wire logic [BPS_SEQ_AW-1:0] seq_loop_to_in, // Loop start entry
	input wire logic [BPS_LEN_W-1:0] seq_loop_cnt_in, // Loop repeats, zero endless
	input wire logic mem_we_in, // Pattern memory word write
	input wire logic [BPS_WORD_AW-1:0] mem_addr_in, // Word address
	input wire logic [BPS_MEM_DW-1:0] mem_data_in, // Word data, software PRBS prepared
	input wire logic [BPS_ORD_W-1:0] ref_ord_in, // Detector PRBS order
	input wire logic ref_use_mem_in, // Detector reference from memory
	input wire logic symbol_mode_in, // Symbol comparison mode
	input wire logic skip_ordered_sets_in, // Bit mode with skip sets
	input wire logic [BPS_SLOT_W-1:0] ref_slot_in, // User pattern slot
	input wire logic [BPS_MEM_AW-1:0] ref_base_in, // Reference memory start bit
	input wire logic [BPS_LEN_W-1:0] ref_len_in, // Reference length
	output logic tx_data_out, // Serial data to device under test
	output logic tx_valid_out, // Serial bit valid
	input wire logic tx_ready_in, // Link accepts bit
	input wire logic rx_data_in, // Returned serial data pin
	output logic running_out, // Sequence running
	output logic rejected_out, // Configuration rejected
	output logic ref_slot_err_out, // Reference slot illegal
	output logic sync_out, // Pattern synchronized
	output logic [BPS_ERR_W-1:0] err_count_out // Bit errors counted
);
	logic [BPS_MEM_DW-1:0] pat_mem [BPS_MEM_BLOCKS*BPS_MEM_BLOCK_BITS/BPS_MEM_DW];
	logic [2:0] t_kind [BPS_MAX_ENTRIES];
	logic [BPS_LEN_W-1:0] t_len [BPS_MAX_ENTRIES];
	logic [BPS_ORD_W-1:0] t_ord [BPS_MAX_ENTRIES];
	logic [BPS_MEM_AW-1:0] t_base [BPS_MAX_ENTRIES];
	logic t_lend [BPS_MAX_ENTRIES];
	logic [BPS_SEQ_AW-1:0] t_lto [BPS_MAX_ENTRIES];
	logic [BPS_LEN_W-1:0] t_lcnt [BPS_MAX_ENTRIES];
	bps_state_e state;
	logic [BPS_SEQ_AW-1:0] idx;
	logic [BPS_LEN_W-1:0] bit_cnt;
	logic [BPS_LEN_W-1:0] loop_cnt;
	logic [BPS_MEM_AW-1:0] mem_ptr;
	logic [BPS_LFSR_W-1:0] gen_lfsr;
	logic [BPS_ORD_W-1:0] clk_ph;
	logic clk_lvl;
	logic fifo_ready;
	logic fifo_bit;
	logic [BPS_LFSR_W-1:0] ref_lfsr;
	logic [BPS_MEM_AW-1:0] ref_ptr;
	logic [BPS_LEN_W-1:0] ref_pos;
	logic [2:0] rx_sync;
	logic rx_bit;
	logic rx_new;
	logic [BPS_SYNC_WIN_W-1:0] win_cnt;
	logic [BPS_SYNC_WIN_W-1:0] win_err;
	// ----------------------------------------
	// Control decode
	// ----------------------------------------
	wire cfg_bad = ({1'b0, num_blocks_in} + {1'b0, num_loops_in} > (BPS_SEQ_AW+1)'(BPS_MAX_ENTRIES)) ||
		(num_blocks_in == '0);
	wire [2:0] cur_kind = t_kind[idx];
	wire [BPS_ORD_W-1:0] cur_ord = t_ord[idx];
	wire blk_last_bit = (bit_cnt + 32'h1 >= t_len[idx]);
	wire seq_last = (idx + 7'h01 >= num_blocks_in);
	wire loop_taken = t_lend[idx] && ((t_lcnt[idx] == '0) || (loop_cnt + 32'h1 < t_lcnt[idx]));
	wire step = (state == BPS_ST_RUN) && fifo_ready;
	wire mem_bit = pat_mem[mem_ptr[BPS_MEM_AW-1:BPS_WORD_SEL_W]][mem_ptr[BPS_WORD_SEL_W-1:0]];
	wire ref_mode_ok = !(symbol_mode_in || !skip_ordered_sets_in) ||
		(ref_use_mem_in && ref_slot_in < BPS_SLOT_W'(BPS_SLOTS));
	wire ord_ok = (ref_ord_in >= BPS_ORD_W'(BPS_ORD_MIN)) && (ref_ord_in <= BPS_ORD_W'(BPS_ORD_MAX));
	// Block output selection
	logic next_bit;
	always_comb
	begin
		next_bit = 1'b0;
		unique case (cur_kind)
			BPS_BLK_PAUSE0: next_bit = 1'b0;
			BPS_BLK_PAUSE1: next_bit = 1'b1;
			BPS_BLK_CLOCK: next_bit = clk_lvl;
			BPS_BLK_HWPRBS: next_bit = bps_msb(gen_lfsr, cur_ord);
			BPS_BLK_MEMORY: next_bit = mem_bit;
			default: next_bit = 1'b0;
		endcase
	end
	// ----------------------------------------
	// Pattern memory and sequence table
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (mem_we_in)
			pat_mem[mem_addr_in] <= mem_data_in;
		if (seq_we_in && seq_addr_in < BPS_SEQ_AW'(BPS_MAX_ENTRIES))
		begin
			t_kind[seq_addr_in] <= seq_kind_in;
			t_len[seq_addr_in] <= seq_len_in;
			t_ord[seq_addr_in] <= seq_ord_in;
			t_base[seq_addr_in] <= seq_base_in;
			t_lend[seq_addr_in] <= seq_loop_end_in;
			t_lto[seq_addr_in] <= seq_loop_to_in;
			t_lcnt[seq_addr_in] <= seq_loop_cnt_in;
		end
	end
	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			state <= BPS_ST_IDLE;
			idx <= '0;
			bit_cnt <= '0;
			loop_cnt <= '0;
			mem_ptr <= '0;
			gen_lfsr <= 23'h000001;
			clk_ph <= '0;
			clk_lvl <= 1'b0;
			clk_sel_aux_out <= 1'b0;
		end
		else
		begin
			clk_sel_aux_out <= clk_sel_aux_in;
			if (stop_in)
				state <= BPS_ST_IDLE;
			else if (start_in)
			begin
				state <= cfg_bad ? BPS_ST_REJECT : BPS_ST_RUN;
				idx <= '0;
				bit_cnt <= '0;
				loop_cnt <= '0;
				mem_ptr <= t_base[0];
				gen_lfsr <= 23'h000001;
				clk_ph <= '0;
				clk_lvl <= 1'b0;
			end
			else if (step)
			begin
				gen_lfsr <= bps_step(gen_lfsr, cur_ord);
				mem_ptr <= mem_ptr + 25'h0000001;
				if (clk_ph + 5'h01 >= cur_ord)
				begin
					clk_ph <= '0;
					clk_lvl <= !clk_lvl;
				end
				else
					clk_ph <= clk_ph + 5'h01;
				if (blk_last_bit)
				begin
					bit_cnt <= '0;
					clk_ph <= '0;
					clk_lvl <= 1'b0;
					gen_lfsr <= 23'h000001;
					if (loop_taken)
					begin
						loop_cnt <= loop_cnt + 32'h1;
						idx <= t_lto[idx];
						mem_ptr <= t_base[t_lto[idx]];
					end
					else
					begin
						if (t_lend[idx])
							loop_cnt <= '0;
						idx <= seq_last ? '0 : idx + 7'h01;
						mem_ptr <= t_base[seq_last ? 7'h00 : idx + 7'h01];
					end
				end
				else
					bit_cnt <= bit_cnt + 32'h1;
			end
		end
	end
	assign running_out = (state == BPS_ST_RUN);
	assign rejected_out = (state == BPS_ST_REJECT);
	bps_fifo #(.WIDTH(1), .DEPTH(BPS_FIFO_DEPTH)) u_fifo
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.wr_data_in(next_bit),
		.wr_valid_in(state == BPS_ST_RUN),
		.wr_ready_out(fifo_ready),
		.rd_data_out(fifo_bit),
		.rd_valid_out(tx_valid_out),
		.rd_ready_in(tx_ready_in)
	);
	assign tx_data_out = fifo_bit;
	// ----------------------------------------
	// Error detector
	// ----------------------------------------
	wire ref_bit = ref_use_mem_in ? pat_mem[ref_ptr[BPS_MEM_AW-1:BPS_WORD_SEL_W]][ref_ptr[BPS_WORD_SEL_W-1:0]]
		: bps_msb(ref_lfsr, ref_ord_in);
	wire mismatch = rx_bit ^ ref_bit;
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_sync <= '0;
			rx_bit <= 1'b0;
			rx_new <= 1'b0;
			ref_lfsr <= 23'h000001;
			ref_ptr <= '0;
			ref_pos <= '0;
			err_count_out <= '0;
			win_cnt <= '0;
			win_err <= '0;
			sync_out <= 1'b0;
			ref_slot_err_out <= 1'b0;
		end
		else
		begin
			rx_sync <= {rx_sync[1:0], rx_data_in};
			rx_new <= (rx_sync[2] == rx_sync[1]);
			if (rx_sync[2] == rx_sync[1])
				rx_bit <= rx_sync[1];
			ref_slot_err_out <= !ref_mode_ok || (!ref_use_mem_in && !ord_ok);
			if (state != BPS_ST_RUN)
			begin
				ref_lfsr <= 23'h000001;
				ref_ptr <= ref_base_in;
				ref_pos <= '0;
			end
			else if (rx_new)
			begin
				ref_lfsr <= bps_step(ref_lfsr, ref_ord_in);
				ref_pos <= (ref_pos + 32'h1 >= ref_len_in) ? '0 : ref_pos + 32'h1;
				ref_ptr <= (ref_pos + 32'h1 >= ref_len_in) ? ref_base_in : ref_ptr + 25'h0000001;
				if (mismatch && ref_mode_ok)
					err_count_out <= err_count_out + 32'h1;
				if (win_cnt == BPS_SYNC_WIN_W'(BPS_SYNC_WIN - 1))
				begin
					win_cnt <= '0;
					win_err <= '0;
					sync_out <= ((win_err + BPS_SYNC_WIN_W'(mismatch)) <= BPS_SYNC_MAX_ERR);
				end
				else
				begin
					win_cnt <= win_cnt + 7'h01;
					win_err <= win_err + BPS_SYNC_WIN_W'(mismatch);
				end
			end
		end
	end
endmodule

// ===== test/bps_sequencer_sva.sv
`timescale 1ns/100ps
// ----
// Sequencer checks
// ----
module bps_chk
	import bps_pkg::*;
(
	input wire logic clk_in, // Clock
	input wire logic sys_rst_in, // Reset
	input wire logic clk_sel_aux_in, // Source
	input wire logic clk_sel_aux_out, // Source
	input wire logic start_in, // Start
	input wire logic stop_in, // Stop
	input wire logic [BPS_SEQ_AW-1:0] num_blocks_in, // Blocks
	input wire logic [BPS_SEQ_AW-1:0] num_loops_in, // Loops
	input wire logic ref_use_mem_in, // Memory ref
	input wire logic symbol_mode_in, // Symbols
	input wire logic skip_ordered_sets_in, // Skip sets
	input wire logic [BPS_SLOT_W-1:0] ref_slot_in, // Slot
	input wire logic [BPS_ORD_W-1:0] ref_ord_in, // Detector order
	input wire logic tx_data_out, // Bit
	input wire logic tx_valid_out, // Valid
	input wire logic tx_ready_in, // Ready
	input wire logic running_out, // Running
	input wire logic rejected_out, // Rejected
	input wire logic ref_slot_err_out, // Slot error
	input wire logic [BPS_ERR_W-1:0] err_count_out // Errors
);
	logic [7:0] cfg_sum;
	logic cfg_bad;
	logic slot_bad;
	assign cfg_sum = 8'(num_blocks_in) + 8'(num_loops_in);
	assign cfg_bad = (cfg_sum > 8'h78) || (num_blocks_in == 7'h00);
	assign slot_bad = ((symbol_mode_in || !skip_ordered_sets_in) && (!ref_use_mem_in || ref_slot_in > 4'hB)) ||
		(!ref_use_mem_in && (ref_ord_in < 5'(BPS_ORD_MIN) || ref_ord_in > 5'(BPS_ORD_MAX)));
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	property p_reject; start_in && !stop_in && cfg_bad |=> rejected_out && !running_out; endproperty
	a_reject: assert property (p_reject) else $error("bad config not rejected");
	property p_accept; start_in && !stop_in && !cfg_bad |=> running_out && !rejected_out; endproperty
	a_accept: assert property (p_accept) else $error("good config not started");
	property p_stop; stop_in |=> !running_out; endproperty
	a_stop: assert property (p_stop) else $error("still running after stop");
	property p_excl; !(running_out && rejected_out); endproperty
	a_excl: assert property (p_excl) else $error("running and rejected together");
	property p_clksel; !$past(sys_rst_in) |-> clk_sel_aux_out == $past(clk_sel_aux_in); endproperty
	a_clksel: assert property (p_clksel) else $error("clock select not followed");
	property p_hold; tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out); endproperty
	a_hold: assert property (p_hold) else $error("stalled bit lost");
	property p_err; !$past(sys_rst_in) |-> err_count_out - $past(err_count_out) <= 32'h1; endproperty
	a_err: assert property (p_err) else $error("error count jumped");
	property p_slot; !$past(sys_rst_in) |-> ref_slot_err_out == $past(slot_bad); endproperty
	a_slot: assert property (p_slot) else $error("slot error flag wrong");
endmodule

bind bps_sequencer bps_chk chk_i (.*);

// ===== test/bps_dut_model.sv
`timescale 1ns/100ps
// ----
// Device under test: loops bits back
// ----
module bps_dut_model
(
	input wire logic clk_in, // Clock
	input wire logic stall_in, // Hold off bits
	input wire logic invert_in, // Return inverted bits
	input wire logic tx_data_in, // Offered bit
	input wire logic tx_valid_in, // Bit present
	output logic tx_ready_out, // Accepting
	output logic rx_data_out // Returned bit
);
	initial
	begin
		tx_ready_out = 1'b0;
		rx_data_out = 1'b0;
	end
	// Idle line flips so no stale level is seen
	always @(negedge clk_in)
	begin
		tx_ready_out <= !stall_in;
		rx_data_out <= tx_valid_in ? (tx_data_in ^ invert_in) : !rx_data_out;
	end
endmodule

// ===== test/tb.sv
`timescale 1ns/100ps
module tb
	import bps_pkg::*;
;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, clk_sel_aux_in = 1'b0, start_in = 1'b0, stop_in = 1'b0;
	logic seq_we_in = 1'b0, seq_loop_end_in = 1'b0, mem_we_in = 1'b0, ref_use_mem_in = 1'b0;
	logic symbol_mode_in = 1'b0, skip_ordered_sets_in = 1'b1, stall = 1'b0, invert = 1'b0, cap = 1'b0;
	logic [BPS_SEQ_AW-1:0] num_blocks_in = '0, num_loops_in = '0, seq_addr_in = '0, seq_loop_to_in = '0;
	logic [2:0] seq_kind_in = '0;
	logic [BPS_LEN_W-1:0] seq_len_in = '0, seq_loop_cnt_in = '0, ref_len_in = '0;
	logic [BPS_ORD_W-1:0] seq_ord_in = '0, ref_ord_in = 5'h07;
	logic [BPS_MEM_AW-1:0] seq_base_in = '0, ref_base_in = '0;
	logic [BPS_WORD_AW-1:0] mem_addr_in = '0;
	logic [BPS_MEM_DW-1:0] mem_data_in = '0;
	logic [BPS_SLOT_W-1:0] ref_slot_in = '0;
	logic clk_sel_aux_out, tx_data_out, tx_valid_out, tx_ready_in, rx_data_in, running_out, rejected_out;
	logic ref_slot_err_out, sync_out;
	logic [BPS_ERR_W-1:0] err_count_out, e0;
	int num_errors = 0, num_checks = 0, cyc = 0, ones;
	logic q[$];
	bps_sequencer uut (.*);
	bps_dut_model dut (.clk_in(clk_in), .stall_in(stall), .invert_in(invert), .tx_data_in(tx_data_out),
		.tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready_in), .rx_data_out(rx_data_in));
	always #25 clk_in = !clk_in;
	always @(posedge clk_in)
		if (cap && tx_valid_out && tx_ready_in)
			q.push_back(tx_data_out);
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	// ----
	// Helpers
	// ----
	task print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic ent(input int a, k, l, o, b, e, t, c);
		seq_addr_in = 7'(a);
		seq_kind_in = 3'(k);
		seq_len_in = 32'(l);
		seq_ord_in = 5'(o);
		seq_base_in = 25'(b);
		seq_loop_end_in = 1'(e);
		seq_loop_to_in = 7'(t);
		seq_loop_cnt_in = 32'(c);
		seq_we_in = 1'b1;
		tick(1);
		seq_we_in = 1'b0;
		tick(1);
	endtask
	task automatic mem(input int a, input logic [31:0] d);
		mem_addr_in = 20'(a);
		mem_data_in = d;
		mem_we_in = 1'b1;
		tick(1);
		mem_we_in = 1'b0;
		tick(1);
	endtask
	// Stop, drain stale bits, then start a fresh capture
	task automatic go(input int nb, nl);
		stop_in = 1'b1;
		tick(1);
		stop_in = 1'b0;
		tick(6);
		num_blocks_in = 7'(nb);
		num_loops_in = 7'(nl);
		start_in = 1'b1;
		tick(1);
		start_in = 1'b0;
		q.delete();
		cap = 1'b1;
	endtask
	task automatic grab(input int n);
		int w = 0;
		while (q.size() < n && w < 2000)
		begin
			tick(1);
			w++;
		end
		cap = 1'b0;
		chk("bit count", 32'(n), 32'(q.size()));
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_config();
		go(100, 21);
		chk("rejected", 32'h1, 32'(rejected_out));
		go(0, 0);
		chk("rejected", 32'h1, 32'(rejected_out));
		go(100, 20);
		chk("running", 32'h1, 32'(running_out));
		chk("rejected", 32'h0, 32'(rejected_out));
		cap = 1'b0;
	endtask
	task automatic t_pause();
		logic [0:10] pp = 11'b11100111001;
		ent(0, 1, 3, 0, 0, 0, 0, 0);
		ent(1, 0, 2, 0, 0, 1, 0, 2);
		ent(2, 1, 1, 0, 0, 0, 0, 0);
		go(3, 1);
		tick(6);
		stall = 1'b1;
		tick(10);
		stall = 1'b0;
		grab(22);
		for (int i = 0; i < 22; i++)
			chk("pause bit", 32'(pp[i % 11]), 32'(q[i]));
	endtask
	task automatic t_mem();
		logic [7:0] w = 8'hB4;
		mem(1, 32'h000000B4);
		ent(0, 4, 8, 0, 32, 0, 0, 0);
		go(1, 0);
		grab(16);
		for (int i = 0; i < 16; i++)
			chk("memory bit", 32'(w[i % 8]), 32'(q[i]));
	endtask
	task automatic t_prbs();
		ent(0, 2, 64, 2, 0, 0, 0, 0);
		go(1, 0);
		grab(12);
		for (int i = 0; i < 10; i++)
			chk("clock bit", 32'(!q[i]), 32'(q[i + 2]));
		ent(0, 3, 254, 7, 0, 0, 0, 0);
		go(1, 0);
		grab(254);
		ones = 0;
		for (int i = 0; i < 127; i++)
		begin
			chk("prbs period", 32'(q[i]), 32'(q[i + 127]));
			ones += int'(q[i]);
		end
		chk("prbs ones", 32'h40, 32'(ones));
	endtask
	task automatic t_detect();
		mem(4, 32'h0);
		ref_use_mem_in = 1'b1;
		ref_base_in = 25'h80;
		ref_len_in = 32'h20;
		ent(0, 0, 8, 0, 0, 0, 0, 0);
		go(1, 0);
		cap = 1'b0;
		tick(200);
		e0 = err_count_out;
		tick(10);
		chk("error count", e0, err_count_out);
		chk("sync", 32'h1, 32'(sync_out));
		invert = 1'b1;
		tick(20);
		e0 = err_count_out;
		tick(10);
		chk("error count", e0 + 32'h0000000A, err_count_out);
		tick(150);
		chk("sync", 32'h0, 32'(sync_out));
		invert = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			symbol_mode_in = (i < 2);
			skip_ordered_sets_in = (i != 2);
			ref_slot_in = (i == 1) ? 4'hB : 4'hC;
			tick(2);
			chk("slot error", 32'(i % 2 == 0), 32'(ref_slot_err_out));
		end
		ref_use_mem_in = 1'b0;
		ref_ord_in = 5'h06;
		tick(2);
		chk("order error", 32'h1, 32'(ref_slot_err_out));
		ref_ord_in = 5'h07;
		tick(2);
		chk("order error", 32'h0, 32'(ref_slot_err_out));
		clk_sel_aux_in = 1'b1;
		tick(2);
		chk("clock select", 32'h1, 32'(clk_sel_aux_out));
		clk_sel_aux_in = 1'b0;
		tick(2);
		chk("clock select", 32'h0, 32'(clk_sel_aux_out));
	endtask
	initial
	begin
		tick(4);
		sys_rst_in = 1'b0;
		chk("running", 32'h0, 32'(running_out));
		chk("errors", 32'h0, err_count_out);
		t_config();
		t_pause();
		t_mem();
		t_prbs();
		t_detect();
		print_verdict();
	end
endmodule
